// File: hw/tcc_clock_control.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_clock_control import tcc_pkg::*; #(
   parameter int CLK_KHZ_P = CLK_KHZ,
   parameter int BIT_KHZ_P = BIT_CLK_KHZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output var logic [31:0] prdata,
   output var logic pready,
   output var logic pslverr,
   input wire logic oscillator_bank_select,
   input wire logic oscillator_enable,
   output var logic low_band_osc_en,
   output var logic high_band_osc_en,
   output var logic host_clock_out,
   output var logic codec_bit_clock,
   output var logic codec_frame_clock,
   input wire logic codec_sample_input,
   output var logic codec_sample_output,
   input wire logic hard_reset_n,
   input wire logic device_select_n,
   input wire logic [3:0] host_addr,
   input wire logic [7:0] host_data_in,
   output var logic [7:0] host_data_out,
   output var logic host_data_oe,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [IRQ_W-1:0] irq_source,
   output var logic interrupt_line_n,
   output var logic antenna_tx_select,
   output var logic synth_band_switch,
   output var logic power_amp_switch,
   output var logic burst_sync_out,
   input wire logic burst_sync_in,
   output var logic modulated_chip_out,
   output var logic modulated_chip_oe,
   input wire logic receiver_bit_in
);
   localparam logic [16:0] STEP = 17'(2 * BIT_KHZ_P);
   localparam logic [16:0] WRAP = 17'(CLK_KHZ_P);

   if (2 * BIT_KHZ_P >= CLK_KHZ_P || CLK_KHZ_P > 65535 || HOST_DIV != 4 || BITS_PER_FRAME != 256 || SYNC_LAT < 2)
   begin : g_bad_cfg
      $error("clock ratio unsupported");
   end

   tcc_pins_t pins;
   logic core_rst;
   logic run;
   logic int_rst_ff;
   logic low_en_ff, high_en_ff;
   logic [1:0] div_cnt_ff;
   logic host_clk_ff;
   logic [15:0] acc_ff;
   logic [16:0] acc_sum;
   logic bit_tgl, bit_rise, bit_fall;
   logic bclk_ff, frame_ff, burst_out_ff, sample_out_ff;
   logic [7:0] bit_cnt_ff, nxt_bit_cnt;
   logic [7:0] shout_ff, nxt_shout, shin_ff, voice_rx_ff;
   logic [SYNC_LAT-1:0] fall_dly_ff, last_dly_ff;
   logic take_bit;
   logic burst_prev_ff;
   logic [7:0] burst_cnt_ff;
   logic [7:0] bank_ff [16];
   logic wr_prev_ff, rd_prev_ff, wr_done, rd_done;
   logic [7:0] hdout_ff;
   logic hoe_ff;
   logic [IRQ_W-1:0] irq_stat_ff, irq_en, irq_clr;
   logic irq_n_ff;
   logic rts_prev_ff;
   logic [1:0] ctrl_ff;
   logic [7:0] voice_tx_ff;
   logic tx_req;
   tcc_rf_state_t rf_state_ff, nxt_rf_state;
   tcc_rf_t rf_ff, nxt_rf;
   logic chip_ff, chip_oe_ff;
   logic [31:0] prdata_ff, rd_val;
   logic pready_ff, pslverr_ff, apb_setup, apb_hit;

   tcc_pin_sync #(.W($bits(tcc_pins_t)), .RST_VAL(PINS_RST)) u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_async({oscillator_bank_select, oscillator_enable, hard_reset_n, codec_sample_input,
         burst_sync_in, receiver_bit_in, device_select_n, read_strobe_n, write_strobe_n,
         host_addr, host_data_in}),
      .pin_sync(pins)
   );

   assign core_rst = !pins.hard_rst_n || int_rst_ff;
   assign run = !core_rst && pins.osc_en;

   // Oscillator pair enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_en_ff <= 1'h0;
         high_en_ff <= 1'h0;
      end else begin
         low_en_ff <= pins.osc_en && !pins.bank_sel;
         high_en_ff <= pins.osc_en && pins.bank_sel;
      end
   end

   // Host clock divider, phase restarts under reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_ff <= 2'h0;
         host_clk_ff <= 1'h0;
      end else if (!run) begin
         div_cnt_ff <= 2'h0;
         host_clk_ff <= 1'h0;
      end else begin
         div_cnt_ff <= div_cnt_ff + 2'h1;
         host_clk_ff <= div_cnt_ff[1];
      end
   end

   // Fractional divider for the codec bit clock
   assign acc_sum = {1'b0, acc_ff} + STEP;
   assign bit_tgl = run && (acc_sum >= WRAP);
   assign bit_rise = bit_tgl && !bclk_ff;
   assign bit_fall = bit_tgl && bclk_ff;
   assign nxt_bit_cnt = bit_cnt_ff + 8'h01;
   assign nxt_shout = (nxt_bit_cnt == FRAME_FIRST) ? voice_tx_ff : {shout_ff[6:0], 1'b0};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_ff <= 16'h0000;
         bclk_ff <= 1'h0;
      end else if (!run) begin
         acc_ff <= 16'h0000;
         bclk_ff <= 1'h0;
      end else if (bit_tgl) begin
         acc_ff <= 16'(acc_sum - WRAP);
         bclk_ff <= !bclk_ff;
      end else begin
         acc_ff <= acc_sum[15:0];
      end
   end

   // Frame timing and outgoing sample, advanced on rising bit edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt_ff <= CNT_RST;
         frame_ff <= 1'h0;
         shout_ff <= 8'h00;
         sample_out_ff <= 1'h0;
         burst_out_ff <= 1'h0;
      end else if (!run) begin
         bit_cnt_ff <= CNT_RST;
         frame_ff <= 1'h0;
         shout_ff <= 8'h00;
         sample_out_ff <= 1'h0;
         burst_out_ff <= 1'h0;
      end else if (bit_rise) begin
         bit_cnt_ff <= nxt_bit_cnt;
         frame_ff <= !nxt_bit_cnt[7];
         shout_ff <= nxt_shout;
         sample_out_ff <= nxt_shout[7];
         burst_out_ff <= nxt_bit_cnt == FRAME_FIRST;
      end
   end

   // Falling edge strobe delayed by the synchroniser latency, so the bit taken
   // is the one the pin held at the falling edge, not the one before it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fall_dly_ff <= '0;
         last_dly_ff <= '0;
      end else if (core_rst) begin
         fall_dly_ff <= '0;
         last_dly_ff <= '0;
      end else begin
         fall_dly_ff <= {fall_dly_ff[SYNC_LAT-2:0], bit_fall};
         last_dly_ff <= {last_dly_ff[SYNC_LAT-2:0], bit_cnt_ff == SAMPLE_LAST};
      end
   end

   assign take_bit = fall_dly_ff[SYNC_LAT-1];

   // Incoming sample, taken on falling bit edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shin_ff <= 8'h00;
         voice_rx_ff <= 8'h00;
      end else if (core_rst) begin
         shin_ff <= 8'h00;
         voice_rx_ff <= 8'h00;
      end else if (take_bit) begin
         shin_ff <= {shin_ff[6:0], pins.codec_in};
         if (last_dly_ff[SYNC_LAT-1]) begin
            voice_rx_ff <= {shin_ff[6:0], pins.codec_in};
         end
      end
   end

   // Burst sync input edge counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         burst_prev_ff <= 1'h0;
         burst_cnt_ff <= 8'h00;
      end else begin
         burst_prev_ff <= pins.burst_in;
         if (core_rst) begin
            burst_cnt_ff <= 8'h00;
         end else if (pins.burst_in && !burst_prev_ff) begin
            burst_cnt_ff <= burst_cnt_ff + 8'h01;
         end
      end
   end

   // Parallel host port
   assign wr_done = !pins.sel_n && pins.wr_n && !wr_prev_ff;
   assign rd_done = !pins.sel_n && pins.rd_n && !rd_prev_ff;
   assign irq_en = bank_ff[HADDR_IRQ][IRQ_W-1:0];
   assign irq_clr = (rd_done && pins.addr == HADDR_IRQ) ? hdout_ff[IRQ_W-1:0] : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_prev_ff <= 1'h1;
         rd_prev_ff <= 1'h1;
      end else begin
         wr_prev_ff <= pins.wr_n;
         rd_prev_ff <= pins.rd_n;
      end
   end

   // Control bytes survive hard reset; only presetn clears them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 16; i++) begin
            bank_ff[i] <= 8'h00;
         end
      end else if (wr_done) begin
         bank_ff[pins.addr] <= pins.data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hoe_ff <= 1'h0;
         hdout_ff <= 8'h00;
      end else begin
         hoe_ff <= !pins.sel_n && !pins.rd_n;
         hdout_ff <= (pins.addr == HADDR_IRQ) ? {4'h0, irq_stat_ff} : bank_ff[pins.addr];
      end
   end

   // Sticky interrupt status, a new event wins over a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_ff <= '0;
         irq_n_ff <= 1'h1;
      end else if (core_rst) begin
         irq_stat_ff <= '0;
         irq_n_ff <= 1'h1;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~irq_clr) | (irq_source & irq_en);
         irq_n_ff <= ~|(irq_stat_ff & irq_en);
      end
   end

   // Transmit request bit change triggers a one cycle internal reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rts_prev_ff <= 1'h0;
         int_rst_ff <= 1'h0;
      end else begin
         rts_prev_ff <= bank_ff[HADDR_CFG_HI][RTS_BIT];
         int_rst_ff <= rts_prev_ff != bank_ff[HADDR_CFG_HI][RTS_BIT];
      end
   end

   // Radio switching: synth, then antenna, then amplifier; when tx_req falls amplifier first, then antenna and synth together; core_rst drops all at once
   assign tx_req = ctrl_ff[CTRL_TX_EN] && !bank_ff[HADDR_CFG_HI][RTS_BIT];

   always_comb begin
      nxt_rf_state = rf_state_ff;
      unique case (rf_state_ff)
         RF_RX: if (tx_req) nxt_rf_state = RF_PLL;
         RF_PLL: nxt_rf_state = tx_req ? RF_ANT : RF_RX;
         RF_ANT: nxt_rf_state = tx_req ? RF_TX : RF_PA_OFF;
         RF_TX: if (!tx_req) nxt_rf_state = RF_PA_OFF;
         RF_PA_OFF: nxt_rf_state = RF_RX;
         default: nxt_rf_state = RF_RX;
      endcase
      if (core_rst) begin
         nxt_rf_state = RF_RX;
      end
      nxt_rf.synth = nxt_rf_state != RF_RX;
      nxt_rf.antenna = nxt_rf_state == RF_ANT || nxt_rf_state == RF_TX || nxt_rf_state == RF_PA_OFF;
      nxt_rf.pa = nxt_rf_state == RF_TX;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rf_state_ff <= RF_RX;
         rf_ff <= '0;
         chip_ff <= 1'h0;
         chip_oe_ff <= 1'h0;
      end else begin
         rf_state_ff <= nxt_rf_state;
         rf_ff <= nxt_rf;
         chip_ff <= nxt_rf.antenna && ctrl_ff[CTRL_CHIP];
         chip_oe_ff <= nxt_rf.antenna;
      end
   end

   // APB slave, one wait-free access phase
   assign apb_setup = psel && !penable;
   assign apb_hit = paddr == OFF_CTRL || paddr == OFF_STATUS || paddr == OFF_VOICE_TX || paddr == OFF_VOICE_RX;

   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (paddr)
         OFF_CTRL: rd_val[1:0] = ctrl_ff;
         OFF_STATUS: begin
            rd_val[ST_TX_ON] = rf_ff.pa;
            rd_val[ST_LOW] = low_en_ff;
            rd_val[ST_HIGH] = high_en_ff;
            rd_val[ST_HARD_OK] = pins.hard_rst_n;
            rd_val[ST_RX_BIT] = pins.rx_bit;
            rd_val[ST_BURST_LSB +: 8] = burst_cnt_ff;
         end
         OFF_VOICE_TX: rd_val[7:0] = voice_tx_ff;
         OFF_VOICE_RX: rd_val[7:0] = voice_rx_ff;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'h0;
         pslverr_ff <= 1'h0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= apb_setup;
         pslverr_ff <= apb_setup && !apb_hit;
         if (apb_setup) begin
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= 2'h0;
         voice_tx_ff <= 8'h00;
      end else if (psel && penable && pready_ff && pwrite) begin
         if (paddr == OFF_CTRL) ctrl_ff <= pwdata[1:0];
         if (paddr == OFF_VOICE_TX) voice_tx_ff <= pwdata[7:0];
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign low_band_osc_en = low_en_ff;
   assign high_band_osc_en = high_en_ff;
   assign host_clock_out = host_clk_ff;
   assign codec_bit_clock = bclk_ff;
   assign codec_frame_clock = frame_ff;
   assign codec_sample_output = sample_out_ff;
   assign host_data_out = hdout_ff;
   assign host_data_oe = hoe_ff;
   assign interrupt_line_n = irq_n_ff;
   assign antenna_tx_select = rf_ff.antenna;
   assign synth_band_switch = rf_ff.synth;
   assign power_amp_switch = rf_ff.pa;
   assign burst_sync_out = burst_out_ff;
   assign modulated_chip_out = chip_ff;
   assign modulated_chip_oe = chip_oe_ff;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_bank_select: assert property (high_band_osc_en |-> $past(pins.bank_sel) && $past(pins.osc_en))
      else $error("high band enabled without select");
   chk_osc_off: assert property (!pins.osc_en |=> !low_band_osc_en && !high_band_osc_en)
      else $error("oscillator running while disabled");
   chk_host_div: assert property (run && div_cnt_ff == 2'h2 |=> $rose(host_clock_out))
      else $error("host clock phase wrong");
   chk_bit_rate: assert property ($changed(codec_bit_clock) && run |=> !$changed(codec_bit_clock))
      else $error("bit clock too fast");
   chk_fall_sample: assert property (take_bit && !core_rst |=> shin_ff[0] == $past(codec_sample_input, SYNC_LAT + 1))
      else $error("codec input not sampled on fall");
   chk_frame_start: assert property ($rose(codec_frame_clock) |-> $past(bit_cnt_ff) == CNT_RST)
      else $error("frame starts off boundary");
   chk_hard_hold: assert property (!pins.hard_rst_n |=> !host_clock_out && !codec_bit_clock)
      else $error("clock runs during hard reset");
   chk_select_read: assert property (host_data_oe |-> !$past(pins.sel_n) && !$past(pins.rd_n))
      else $error("data driven without select");
   chk_irq_or: assert property (!core_rst |=> interrupt_line_n == !(|($past(irq_stat_ff) & $past(irq_en))))
      else $error("interrupt line mismatch");
   chk_rts_reset: assert property ($changed(bank_ff[HADDR_CFG_HI][RTS_BIT]) |=> int_rst_ff)
      else $error("no reset on request change");
   chk_pa_order: assert property (power_amp_switch |-> antenna_tx_select && synth_band_switch)
      else $error("amplifier on before antenna");
   chk_pa_off_first: assert property ($fell(power_amp_switch) && !$past(core_rst) |-> antenna_tx_select ##1 !antenna_tx_select)
      else $error("antenna dropped with amplifier");

   cov_tx_on: cover property (rf_state_ff == RF_RX ##1 rf_state_ff == RF_PLL ##1 rf_state_ff == RF_ANT ##1 power_amp_switch);
   cov_frame: cover property ($rose(codec_frame_clock));
   cov_irq: cover property ($fell(interrupt_line_n));
   cov_rx_sample: cover property (bit_fall && bit_cnt_ff == SAMPLE_LAST);
endmodule : tcc_clock_control
`default_nettype wire

// File: hw/tcc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] pin_async,
   output var logic [W-1:0] pin_sync
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] stable_ff;
   logic [W-1:0] agree;

   if (W < 1) begin : g_bad_w
      $error("sync width must be positive");
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
      end else begin
         meta_ff <= pin_async;
         s2_ff <= meta_ff;
         s3_ff <= s2_ff;
      end
   end

   // A bit changes only once the second and third stages agree
   assign agree = ~(s2_ff ^ s3_ff);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stable_ff <= RST_VAL;
      end else begin
         stable_ff <= (s3_ff & agree) | (stable_ff & ~agree);
      end
   end

   assign pin_sync = stable_ff;
endmodule : tcc_pin_sync
`default_nettype wire

// File: inc/tcc_pkg.sv
`default_nettype none
package tcc_pkg;
   // Master clock rate in kHz (100 ns period)
   localparam int CLK_KHZ = 10000;
   localparam int BIT_CLK_KHZ = 2048;
   localparam int FRAME_KHZ = 8;
   localparam int BITS_PER_FRAME = BIT_CLK_KHZ / FRAME_KHZ;
   localparam int HOST_DIV = 4;
   // Clocks from a pin change to its synchronised view being readable
   localparam int SYNC_LAT = 4;
   localparam logic [7:0] SAMPLE_LAST = 8'h07;
   localparam logic [7:0] FRAME_FIRST = 8'h00;
   localparam logic [7:0] CNT_RST = 8'hff;

   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [11:0] OFF_VOICE_TX = 12'h008;
   localparam logic [11:0] OFF_VOICE_RX = 12'h00c;
   localparam int CTRL_TX_EN = 0;
   localparam int CTRL_CHIP = 1;
   localparam int ST_TX_ON = 0;
   localparam int ST_LOW = 1;
   localparam int ST_HIGH = 2;
   localparam int ST_HARD_OK = 3;
   localparam int ST_RX_BIT = 4;
   localparam int ST_BURST_LSB = 8;

   localparam logic [3:0] HADDR_CFG_HI = 4'h1;
   localparam logic [3:0] HADDR_IRQ = 4'h3;
   localparam int RTS_BIT = 7;
   localparam int IRQ_W = 4;

   typedef struct packed {
      logic bank_sel;
      logic osc_en;
      logic hard_rst_n;
      logic codec_in;
      logic burst_in;
      logic rx_bit;
      logic sel_n;
      logic rd_n;
      logic wr_n;
      logic [3:0] addr;
      logic [7:0] data;
   } tcc_pins_t;

   localparam tcc_pins_t PINS_RST = '{bank_sel: 1'h0, osc_en: 1'h0, hard_rst_n: 1'h0,
      codec_in: 1'h0, burst_in: 1'h0, rx_bit: 1'h0, sel_n: 1'h1, rd_n: 1'h1, wr_n: 1'h1,
      addr: 4'h0, data: 8'h00};

   typedef struct packed {
      logic synth;
      logic antenna;
      logic pa;
   } tcc_rf_t;

   typedef enum logic [2:0] {
      RF_RX = 3'b000,
      RF_PLL = 3'b001,
      RF_ANT = 3'b010,
      RF_TX = 3'b011,
      RF_PA_OFF = 3'b100
   } tcc_rf_state_t;
endpackage : tcc_pkg
`default_nettype wire

// File: verification/tcc_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_board_model (
   input wire logic codec_bit_clock,
   input wire logic codec_sample_output,
   input wire logic burst_sync_out,
   output var logic codec_sample_input,
   output var logic burst_sync_in
);
   initial begin
      codec_sample_input = 1'h0;
   end

   // Codec echoes each bit back, moving only just after a rising bit clock
   always @(posedge codec_bit_clock) begin
      #1 codec_sample_input = codec_sample_output;
   end

   // Board loops the burst pulse straight back
   always_comb begin
      burst_sync_in = burst_sync_out;
   end
endmodule : tcc_board_model
`default_nettype wire

// File: verification/transceiver_pin_clock_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module transceiver_pin_clock_control_tb import tcc_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic oscillator_bank_select, oscillator_enable, low_band_osc_en, high_band_osc_en, host_clock_out;
   logic codec_bit_clock, codec_frame_clock, codec_sample_input, codec_sample_output, hard_reset_n;
   logic device_select_n, read_strobe_n, write_strobe_n, host_data_oe, interrupt_line_n, e;
   logic [3:0] host_addr, irq_source;
   logic [7:0] host_data_in, host_data_out, ba;
   logic antenna_tx_select, synth_band_switch, power_amp_switch, burst_sync_out, burst_sync_in;
   logic modulated_chip_out, modulated_chip_oe, receiver_bit_in;
   int fail_count, samples_checked, hc, bc, fc, bs;
   typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] x; logic e;} tcc_row_t;
   tcc_row_t rows [7] = '{
      '{1'h1, OFF_VOICE_TX, 32'ha5, 32'h0, 32'h0, 1'h0},
      '{1'h0, OFF_VOICE_TX, 32'h0, 32'hff, 32'ha5, 1'h0},
      '{1'h1, OFF_STATUS, 32'hff, 32'h0, 32'h0, 1'h0},
      '{1'h0, OFF_STATUS, 32'h0, 32'h1f, 32'h1a, 1'h0},
      '{1'h1, 12'h010, 32'h1, 32'h0, 32'h0, 1'h1},
      '{1'h0, 12'h010, 32'h0, 32'hffffffff, 32'h0, 1'h1},
      '{1'h0, OFF_CTRL, 32'h0, 32'h3, 32'h0, 1'h0}};

   tcc_clock_control i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .oscillator_bank_select, .oscillator_enable, .low_band_osc_en, .high_band_osc_en,
      .host_clock_out, .codec_bit_clock, .codec_frame_clock, .codec_sample_input, .codec_sample_output,
      .hard_reset_n, .device_select_n, .host_addr, .host_data_in, .host_data_out, .host_data_oe,
      .read_strobe_n, .write_strobe_n, .irq_source, .interrupt_line_n, .antenna_tx_select,
      .synth_band_switch, .power_amp_switch, .burst_sync_out, .burst_sync_in, .modulated_chip_out,
      .modulated_chip_oe, .receiver_bit_in);
   tcc_board_model i_board (.codec_bit_clock, .codec_sample_output, .burst_sync_out, .codec_sample_input,
      .burst_sync_in);

   initial begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end

   task report_and_stop;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   task wait_c(input int n);
      repeat (n) @(posedge pclk);
   endtask : wait_c

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n >= 20) begin
         fail_count++;
         report_and_stop();
      end else begin
         r = prdata;
         e = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
      end
   endtask : apb

   task host(input logic sel_n, input logic rd, input logic [3:0] a, input logic [7:0] d, input logic [7:0] x);
      device_select_n <= sel_n; host_addr <= a; host_data_in <= d;
      wait_c(6);
      if (rd) read_strobe_n <= 1'h0; else write_strobe_n <= 1'h0;
      wait_c(8);
      if (rd) `CHK({host_data_oe, host_data_out}, {1'h1, x})
      read_strobe_n <= 1'h1; write_strobe_n <= 1'h1;
      wait_c(8);
      device_select_n <= 1'h1;
      wait_c(2);
   endtask : host

   task pulse(input logic [3:0] s);
      irq_source <= s;
      @(posedge pclk);
      irq_source <= 4'h0;
      wait_c(5);
   endtask : pulse

   task count_edges(input int cyc);
      logic [3:0] prev;
      hc = 0; bc = 0; fc = 0; bs = 0;
      prev = {host_clock_out, codec_bit_clock, codec_frame_clock, burst_sync_out};
      repeat (cyc) begin
         @(posedge pclk);
         if (host_clock_out && !prev[3]) hc++;
         if (codec_bit_clock && !prev[2]) bc++;
         if (codec_frame_clock && !prev[1]) fc++;
         if (burst_sync_out && !prev[0]) bs++;
         prev = {host_clock_out, codec_bit_clock, codec_frame_clock, burst_sync_out};
      end
   endtask : count_edges

   initial begin
      fail_count = 0; samples_checked = 0;
      presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h000; pwdata = 32'h0;
      oscillator_bank_select = 1'h0; oscillator_enable = 1'h1; hard_reset_n = 1'h1; receiver_bit_in = 1'h1;
      device_select_n = 1'h1; read_strobe_n = 1'h1; write_strobe_n = 1'h1; host_addr = 4'h0;
      host_data_in = 8'h00; irq_source = 4'h0;
      wait_c(2);
      `CHK({interrupt_line_n, pready}, 2'h2)
      presetn <= 1'h1;
      wait_c(10);
      for (int i = 0; i < 7; i++) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         `CHK({e, r & rows[i].m}, {rows[i].e, rows[i].x})
      end
      for (int i = 0; i < 4; i++) begin
         oscillator_bank_select <= i[1]; oscillator_enable <= i[0];
         wait_c(6);
         `CHK({high_band_osc_en, low_band_osc_en}, i[0] ? (i[1] ? 2'h2 : 2'h1) : 2'h0)
      end
      oscillator_bank_select <= 1'h0;
      wait_c(6);
      apb(1'h0, OFF_STATUS, 32'h0);
      ba = r[ST_BURST_LSB +: 8];
      count_edges(2500);
      `CHK(hc, 625)
      `CHK(bc inside {[511:513]}, 1'h1)
      `CHK({fc, bs}, {32'd2, 32'd2})
      apb(1'h0, OFF_VOICE_RX, 32'h0);
      `CHK(r[7:0], 8'ha5)
      apb(1'h0, OFF_STATUS, 32'h0);
      `CHK(8'(r[ST_BURST_LSB +: 8] - ba) inside {[2:3]}, 1'h1)
      host(1'h0, 1'h0, HADDR_IRQ, 8'h05, 8'h00);
      pulse(4'h2);
      `CHK(interrupt_line_n, 1'h1)
      pulse(4'h4);
      `CHK(interrupt_line_n, 1'h0)
      host(1'h0, 1'h1, HADDR_IRQ, 8'h00, 8'h04);
      `CHK(interrupt_line_n, 1'h1)
      host(1'h1, 1'h0, HADDR_IRQ, 8'h00, 8'h00);
      pulse(4'h1);
      `CHK(interrupt_line_n, 1'h0)
      host(1'h0, 1'h1, HADDR_IRQ, 8'h00, 8'h01);
      apb(1'h1, OFF_CTRL, 32'h3);
      wait_c(10);
      `CHK({antenna_tx_select, synth_band_switch, power_amp_switch, modulated_chip_oe, modulated_chip_out}, 5'h1f)
      host(1'h0, 1'h0, HADDR_CFG_HI, 8'h80, 8'h00);
      `CHK({antenna_tx_select, synth_band_switch, power_amp_switch, modulated_chip_oe}, 4'h0)
      host(1'h0, 1'h0, HADDR_CFG_HI, 8'h5a, 8'h00);
      wait_c(4);
      `CHK({antenna_tx_select, synth_band_switch, power_amp_switch}, 3'h7)
      apb(1'h1, OFF_CTRL, 32'h0);
      wait_c(10);
      `CHK({antenna_tx_select, synth_band_switch, power_amp_switch}, 3'h0)
      hard_reset_n <= 1'h0;
      wait_c(8);
      count_edges(40);
      `CHK({hc, bc, 31'h0, interrupt_line_n}, {32'd0, 32'd0, 32'd1})
      apb(1'h0, OFF_VOICE_TX, 32'h0);
      `CHK(r[7:0], 8'ha5)
      host(1'h0, 1'h1, HADDR_CFG_HI, 8'h00, 8'h5a);
      hard_reset_n <= 1'h1;
      wait_c(8);
      count_edges(40);
      `CHK(hc, 10)
      report_and_stop();
   end
endmodule : transceiver_pin_clock_control_tb
`default_nettype wire
